// [inc/opp_regs.svh]
// Register offsets, field positions, reset values and timing counts
// Assumes a 10 MHz APB clock and byte addressing of 32-bit registers
`ifndef OPP_REGS_SVH
`define OPP_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_POWER_CTRL   8'h00
`define OFS_TIMING_CFG   8'h04
`define OFS_CUT_CFG      8'h08
`define OFS_POWER_PLUS   8'h0C
`define OFS_EVT_STATUS   8'h10
`define OFS_EVT_CLEAR    8'h14
`define OFS_EVT_ENABLE   8'h18
`define OFS_ADDR_STATUS  8'h1C

// ****************************************
// Field positions
// ****************************************
`define PORTS            4
`define F_CUT_TO_LSB     0
`define F_LIM_TO_LSB     8
`define F_INRUSH_LSB     16
`define F_OFF_REQ_LSB    4
`define F_EVT_CUT_LSB    4
`define F_EVT_LIM_LSB    8
`define SYNC_W           13

// ****************************************
// Reset values
// ****************************************
`define RST_TIMING_CFG   24'h32_0A3C
`define RST_CUT_CFG      12'h333
`define RST_ZERO12       12'h000

// ****************************************
// Addresses and timing
// ****************************************
`define MGMT_ADDR_LOW    7'h20
`define MGMT_ADDR_HIGH   7'h28
`define TICK_US          100
`define CLK_KHZ          10000
`define TICK_CYCLES      ((`TICK_US * `CLK_KHZ) / 1000)

`endif

// [inc/opp_pkg.sv]
// Types for the port overcurrent protection block
// Assumes opp_regs.svh is on the include path
`include "opp_regs.svh"
package opp_pkg;
	typedef enum logic [1:0]
	{
		PORT_OFF    = 2'b00,
		PORT_INRUSH = 2'b01,
		PORT_ON     = 2'b10
	} port_state_e;

	typedef struct packed {
		logic [`SYNC_W-1:0] meta;
		logic [`SYNC_W-1:0] stable;
	} sync_s;

	typedef struct packed {
		logic [7:0] cnt;
		logic [1:0] div;
		logic       expire;
	} timer_s;

	typedef struct packed {
		port_state_e [`PORTS-1:0] st;
		logic [`PORTS-1:0][7:0]   win;
		logic [9:0]               tick_cnt;
		logic [23:0]              timing;
		logic [11:0]              cut_cfg;
		logic [3:0]               hp;
		logic [11:0]              status;
		logic [11:0]              enable;
		logic [1:0]               addr_wait;
		logic                     addr_done;
		logic [6:0]               addr;
		logic [3:0]               pwr;
		logic [3:0]               inr_lim;
		logic [3:0]               fold;
		logic [3:0]               dbl;
		logic                     irq;
		logic                     pready;
		logic                     pslverr;
		logic [31:0]              prdata;
	} opp_s;
endpackage

// [verilog/pin_sync.sv]
// Two-stage synchroniser for all comparator and strap pins
// Assumes inputs are asynchronous levels; freezes with the clock enable
`timescale 1ns/1ns
`default_nettype none
module pin_sync
	import opp_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic [`SYNC_W-1:0] pins,
	output logic      [`SYNC_W-1:0] synced
);
	sync_s q;
	sync_s d;

	always_comb
	begin
		d = q;
		if (ce)
		begin
			d.meta   = pins;
			d.stable = q.meta;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	assign synced = q.stable;
endmodule
`default_nettype wire

// [verilog/port_timer.sv]
// Overload timer: counts down while over, back up slowly while not
// Assumes tick is a one-cycle pulse on the same clock
`timescale 1ns/1ns
`default_nettype none
module port_timer
	import opp_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	input  wire logic       tick,
	input  wire logic       run,
	input  wire logic       over,
	input  wire logic [7:0] max_count,
	output logic            expire
);
	timer_s q;
	timer_s d;

	always_comb
	begin
		d = q;
		if (ce)
		begin
			// Pulse clears only on an enabled cycle so a low enable freezes it too
			d.expire = 1'b0;
			if (!run)
			begin
				d.cnt = max_count;
				d.div = 2'b00;
			end
			else if (tick)
			begin
				if (over)
				begin
					if (q.cnt == 8'h00)
						d.expire = 1'b1;
					else
						d.cnt = q.cnt - 8'h01;
				end
				else
				begin
					// Recovery at a quarter rate keeps repeated bursts fatal
					d.div = q.div + 2'b01;
					if (q.div == 2'b11 && q.cnt < max_count)
						d.cnt = q.cnt + 8'h01;
				end
			end
			if (d.cnt > max_count)
				d.cnt = max_count;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	assign expire = q.expire;

	// ****************************************
	// Checks
	// ****************************************
	a_timer_fires: assert property (@(posedge pclk) disable iff (!presetn)
		ce && run && tick && over && q.cnt == 8'h00 |=> expire)
		else $error("timer did not expire at zero");
	a_timer_slow: assert property (@(posedge pclk) disable iff (!presetn)
		ce && run && tick && !over && q.div != 2'b11 && q.cnt <= max_count |=> q.cnt == $past(q.cnt))
		else $error("timer recovered faster than a quarter rate");
	a_timer_max: assert property (@(posedge pclk) disable iff (!presetn)
		ce && run && $stable(max_count) |=> q.cnt <= max_count)
		else $error("timer above its maximum");
endmodule
`default_nettype wire

// [verilog/port_overcurrent_protection.sv]
// Four-port overcurrent protection sequencer with APB registers
// Assumes comparator pins are asynchronous levels from the analog front end
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module port_overcurrent_protection
	import opp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  cut_over,
	input  wire logic [3:0]  hard_limit_hit,
	input  wire logic [3:0]  inrush_limiting,
	input  wire logic        address_select_pin,
	output logic      [3:0]  port_power_en,
	output logic      [3:0]  inrush_limit_en,
	output logic      [3:0]  foldback_en,
	output logic      [3:0]  foldback_double,
	output logic      [11:0] cut_current_threshold,
	output logic             irq,
	output logic      [6:0]  mgmt_address
);
	localparam logic [9:0] TICK_LAST = 10'(`TICK_CYCLES - 1);

	opp_s                q;
	opp_s                d;
	logic [`SYNC_W-1:0]  synced;
	logic [3:0]          cut_s;
	logic [3:0]          hard_s;
	logic [3:0]          inr_s;
	logic                sel_s;
	logic                tick;
	logic [3:0]          tier_run;
	logic [3:0]          cut_exp;
	logic [3:0]          lim_exp;
	logic                acc;
	logic                wr;
	logic [3:0]          on_req;
	logic [3:0]          off_req;
	logic [11:0]         clr;
	logic [11:0]         ev;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	pin_sync u_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.pins    ({address_select_pin, inrush_limiting, hard_limit_hit, cut_over}),
		.synced  (synced)
	);

	assign cut_s  = synced[3:0];
	assign hard_s = synced[7:4];
	assign inr_s  = synced[11:8];
	assign sel_s  = synced[12];
	assign tick   = ce && q.tick_cnt == TICK_LAST;

	// ****************************************
	// Per-port overload timers
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < `PORTS; g++)
		begin : g_port
			assign tier_run[g] = q.st[g] == PORT_ON;
			port_timer u_cut
			(
				.pclk      (pclk),
				.presetn   (presetn),
				.ce        (ce),
				.tick      (tick),
				.run       (tier_run[g]),
				.over      (cut_s[g]),
				.max_count (q.timing[`F_CUT_TO_LSB +: 8]),
				.expire    (cut_exp[g])
			);
			port_timer u_lim
			(
				.pclk      (pclk),
				.presetn   (presetn),
				.ce        (ce),
				.tick      (tick),
				.run       (tier_run[g]),
				.over      (hard_s[g]),
				.max_count (q.timing[`F_LIM_TO_LSB +: 8]),
				.expire    (lim_exp[g])
			);
		end
	endgenerate

	// ****************************************
	// Bus decode
	// ****************************************
	// One wait state: pready rises in the second access cycle
	assign acc     = ce && psel && penable;
	assign wr      = acc && q.pready && pwrite;
	assign on_req  = (wr && paddr == `OFS_POWER_CTRL) ? pwdata[3:0] : 4'h0;
	assign off_req = (wr && paddr == `OFS_POWER_CTRL) ? pwdata[`F_OFF_REQ_LSB +: 4] : 4'h0;
	assign clr     = (wr && paddr == `OFS_EVT_CLEAR) ? pwdata[11:0] : 12'h000;

	always_comb
	begin
		d = q;
		ev = 12'h000;
		if (ce)
		begin
			d.pready  = 1'b0;
			d.pslverr = 1'b0;
			d.tick_cnt = tick ? 10'h000 : q.tick_cnt + 10'h001;
			if (acc && !q.pready)
			begin
				d.pready = 1'b1;
				d.prdata = 32'h0000_0000;
				unique case (paddr)
					`OFS_POWER_CTRL:  d.prdata[3:0] = q.pwr;
					`OFS_TIMING_CFG:  d.prdata[23:0] = q.timing;
					`OFS_CUT_CFG:     d.prdata[11:0] = q.cut_cfg;
					`OFS_POWER_PLUS:  d.prdata[3:0] = q.hp;
					`OFS_EVT_STATUS:  d.prdata[11:0] = q.status;
					`OFS_EVT_CLEAR:   d.prdata = 32'h0000_0000;
					`OFS_EVT_ENABLE:  d.prdata[11:0] = q.enable;
					`OFS_ADDR_STATUS: d.prdata[6:0] = q.addr;
					default:          d.pslverr = 1'b1;
				endcase
			end
			if (wr)
			begin
				if (paddr == `OFS_TIMING_CFG)
					d.timing = pwdata[23:0];
				if (paddr == `OFS_CUT_CFG)
					d.cut_cfg = pwdata[11:0];
				if (paddr == `OFS_POWER_PLUS)
					d.hp = pwdata[3:0];
				if (paddr == `OFS_EVT_ENABLE)
					d.enable = pwdata[11:0];
			end

			// Strap is read once the synchroniser has filled
			if (!q.addr_done)
			begin
				d.addr_wait = q.addr_wait + 2'b01;
				if (q.addr_wait == 2'b11)
				begin
					d.addr_done = 1'b1;
					d.addr = sel_s ? `MGMT_ADDR_HIGH : `MGMT_ADDR_LOW;
				end
			end

			// ****************************************
			// Port sequencers
			// ****************************************
			// Faults take priority over an off request so the flag is never lost
			for (int i = 0; i < `PORTS; i++)
			begin
				unique case (q.st[i])
					PORT_OFF:
					begin
						if (on_req[i])
						begin
							d.st[i] = PORT_INRUSH;
							d.win[i] = q.timing[`F_INRUSH_LSB +: 8];
						end
					end
					PORT_INRUSH:
					begin
						if (tick && q.win[i] == 8'h00)
						begin
							if (inr_s[i])
							begin
								d.st[i] = PORT_OFF;
								ev[i] = 1'b1;
							end
							else
								d.st[i] = PORT_ON;
						end
						else if (off_req[i])
							d.st[i] = PORT_OFF;
						else if (tick)
							d.win[i] = q.win[i] - 8'h01;
					end
					PORT_ON:
					begin
						if (cut_exp[i])
						begin
							d.st[i] = PORT_OFF;
							ev[`F_EVT_CUT_LSB + i] = 1'b1;
						end
						else if (lim_exp[i])
						begin
							d.st[i] = PORT_OFF;
							ev[`F_EVT_LIM_LSB + i] = 1'b1;
						end
						else if (off_req[i])
							d.st[i] = PORT_OFF;
					end
					default: d.st[i] = PORT_OFF;
				endcase
				d.pwr[i]     = d.st[i] != PORT_OFF;
				d.inr_lim[i] = d.st[i] == PORT_INRUSH;
				d.fold[i]    = d.st[i] == PORT_ON && hard_s[i];
			end
			d.dbl = q.hp;
			// Set beats clear in the same cycle
			d.status = (q.status & ~clr) | ev;
			d.irq = |(d.status & d.enable);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.timing <= `RST_TIMING_CFG;
			q.cut_cfg <= `RST_CUT_CFG;
			q.addr <= `MGMT_ADDR_LOW;
		end
		else
			q <= d;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata                = q.prdata;
	assign pready                = q.pready;
	assign pslverr               = q.pslverr;
	assign port_power_en         = q.pwr;
	assign inrush_limit_en       = q.inr_lim;
	assign foldback_en           = q.fold;
	assign foldback_double       = q.dbl;
	// Host keeps these codes below the hard limit of the chosen curve
	assign cut_current_threshold = q.cut_cfg;
	assign irq                   = q.irq;
	assign mgmt_address          = q.addr;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_inrush_start: assert property (ce && q.st[0] == PORT_OFF && on_req[0]
		|=> q.st[0] == PORT_INRUSH && inrush_limit_en[0])
		else $error("inrush not started on power-on");
	a_inrush_fault: assert property (tick && q.st[0] == PORT_INRUSH && q.win[0] == 8'h00 && inr_s[0]
		|=> q.st[0] == PORT_OFF && q.status[0] ##1 !port_power_en[0])
		else $error("inrush fault not handled");
	a_tier_gated: assert property (q.st[0] != PORT_ON |-> !tier_run[0] && !foldback_en[0])
		else $error("tier protection active outside on state");
	a_cut_off: assert property (ce && cut_exp[0] && q.st[0] == PORT_ON
		|=> q.st[0] == PORT_OFF && q.status[`F_EVT_CUT_LSB])
		else $error("cut expiry did not power off");
	a_limit_off: assert property (ce && lim_exp[0] && !cut_exp[0] && q.st[0] == PORT_ON
		|=> q.st[0] == PORT_OFF && q.status[`F_EVT_LIM_LSB])
		else $error("limit expiry did not power off");
	a_foldback: assert property (ce && q.st[0] == PORT_ON && hard_s[0] && !cut_exp[0] && !lim_exp[0]
		&& !off_req[0] |=> foldback_en[0])
		else $error("foldback missing at hard limit");
	a_curve_select: assert property (ce |=> foldback_double == $past(q.hp))
		else $error("foldback curve not from high-power select");
	a_irq_gate: assert property (ce && !wr && !(|((q.status | ev) & q.enable))
		|=> !irq)
		else $error("interrupt raised while disabled");
	a_addr_strap: assert property (ce && !q.addr_done && q.addr_wait == 2'b11
		|=> mgmt_address == ($past(sel_s) ? `MGMT_ADDR_HIGH : `MGMT_ADDR_LOW))
		else $error("strap address wrong");

	c_power_up: cover property (q.st[0] == PORT_INRUSH ##1 q.st[0] == PORT_ON);
	c_cut_trip: cover property (cut_exp[0] ##1 q.status[`F_EVT_CUT_LSB]);
	c_limit_trip: cover property (lim_exp[3] ##1 q.status[`F_EVT_LIM_LSB + 3]);
endmodule
`default_nettype wire

// [verif/pd_load.sv]
// Powered device load model: drives the per-port comparator levels
// Assumes the bench picks a load mode per port: 0 good, 1 stuck inrush, 2 overload, 3 short
`timescale 1ns/1ns
`default_nettype none
module pd_load
(
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic [3:0]      port_power_en,
	input  wire logic [3:0]      inrush_limit_en,
	input  wire logic [3:0][1:0] load_mode,
	output logic      [3:0]      cut_over,
	output logic      [3:0]      hard_limit_hit,
	output logic      [3:0]      inrush_limiting
);
	// ****************************************
	// Load behaviour
	// ****************************************
	// Unpowered ports draw nothing, so every comparator reads low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cut_over        <= 4'h0;
			hard_limit_hit  <= 4'h0;
			inrush_limiting <= 4'h0;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				inrush_limiting[i] <= port_power_en[i] & inrush_limit_en[i] & (load_mode[i] == 2'd1);
				cut_over[i]        <= port_power_en[i] & (load_mode[i] == 2'd2);
				hard_limit_hit[i]  <= port_power_en[i] & (load_mode[i] == 2'd3);
			end
		end
	end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench: APB register access plus per-port fault scenarios
// Assumes opp_regs.svh on the include path and pd_load as the far side
`timescale 1ns/1ns
`default_nettype none
`include "opp_regs.svh"
module tb;
	logic            pclk;
	logic            presetn;
	logic            ce;
	logic            psel;
	logic            penable;
	logic            pwrite;
	logic            address_select_pin;
	logic [7:0]      paddr;
	logic [31:0]     pwdata;
	logic [31:0]     prdata;
	logic [31:0]     rdata_v;
	logic            pready;
	logic            pslverr;
	logic            err_v;
	logic [3:0]      cut_over;
	logic [3:0]      hard_limit_hit;
	logic [3:0]      inrush_limiting;
	logic [3:0]      port_power_en;
	logic [3:0]      inrush_limit_en;
	logic [3:0]      foldback_en;
	logic [3:0]      foldback_double;
	logic [11:0]     cut_current_threshold;
	logic            irq;
	logic [6:0]      mgmt_address;
	logic [3:0][1:0] load_mode;
	int              err_count;
	int              n_compared;
	int              cyc = 0;

	port_overcurrent_protection dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cut_over(cut_over), .hard_limit_hit(hard_limit_hit),
		.inrush_limiting(inrush_limiting), .address_select_pin(address_select_pin),
		.port_power_en(port_power_en), .inrush_limit_en(inrush_limit_en), .foldback_en(foldback_en),
		.foldback_double(foldback_double), .cut_current_threshold(cut_current_threshold), .irq(irq),
		.mgmt_address(mgmt_address));

	pd_load load (.pclk(pclk), .presetn(presetn), .port_power_en(port_power_en),
		.inrush_limit_en(inrush_limit_en), .load_mode(load_mode), .cut_over(cut_over),
		.hard_limit_hit(hard_limit_hit), .inrush_limiting(inrush_limiting));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic give_verdict();
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Waits for pready with no assumed latency; a bounded count stops a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			check("pready", 32'h0, 32'h1);
		rdata_v = prdata;
		err_v   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		check(what, rdata_v, exp);
	endtask

	task automatic wait_pwr(input logic [3:0] exp);
		int n;
		n = 0;
		while (port_power_en !== exp && n < 10000)
		begin
			@(posedge pclk);
			n++;
		end
		check("port power", 32'(port_power_en), 32'(exp));
	endtask

	task automatic do_reset(input logic pin);
		presetn            <= 1'b0;
		address_select_pin <= pin;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask

	// ****************************************
	// Clock and timeout
	// ****************************************
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Whole run is about 20000 cycles
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			err_count++;
			give_verdict();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		{psel, penable, pwrite, presetn, address_select_pin} = 5'h0;
		ce         = 1'b1;
		paddr      = 8'h00;
		pwdata     = 32'h0000_0000;
		load_mode  = {2'd3, 2'd2, 2'd1, 2'd0};
		err_count  = 0;
		n_compared = 0;
		do_reset(1'b0);
		check("address port", 32'(mgmt_address), 32'h0000_0020);
		rd_chk(`OFS_ADDR_STATUS, 32'h0000_0020, "address reg");
		check("cut threshold", 32'(cut_current_threshold), 32'h0000_0333);
		rd_chk(`OFS_TIMING_CFG, 32'h0032_0A3C, "timing reset");
		rd_chk(8'h40, 32'h0000_0000, "unmapped data");
		check("unmapped error", 32'(err_v), 32'h0000_0001);
		// Short timing fields keep each fault to a few thousand cycles
		apb(1'b1, `OFS_TIMING_CFG, 32'h0001_0101);
		rd_chk(`OFS_TIMING_CFG, 32'h0001_0101, "timing");
		apb(1'b1, `OFS_CUT_CFG, 32'h0000_0765);
		repeat (2) @(posedge pclk);
		check("cut threshold", 32'(cut_current_threshold), 32'h0000_0765);
		apb(1'b1, `OFS_POWER_PLUS, 32'h0000_0008);
		repeat (2) @(posedge pclk);
		check("double curve", 32'(foldback_double), 32'h0000_0008);
		apb(1'b1, `OFS_POWER_CTRL, 32'h0000_000F);
		repeat (3) @(posedge pclk);
		check("inrush en", 32'(inrush_limit_en), 32'h0000_000F);
		check("power en", 32'(port_power_en), 32'h0000_000F);
		check("no foldback in inrush", 32'(foldback_en), 32'h0000_0000);
		wait_pwr(4'hD);
		repeat (4) @(posedge pclk);
		check("inrush over", 32'(inrush_limit_en), 32'h0000_0000);
		check("foldback", 32'(foldback_en), 32'h0000_0008);
		rd_chk(`OFS_EVT_STATUS, 32'h0000_0002, "inrush flag");
		wait_pwr(4'h1);
		rd_chk(`OFS_EVT_STATUS, 32'h0000_0842, "fault flags");
		check("masked irq", 32'(irq), 32'h0000_0000);
		apb(1'b1, `OFS_EVT_ENABLE, 32'h0000_0040);
		repeat (2) @(posedge pclk);
		check("irq on", 32'(irq), 32'h0000_0001);
		apb(1'b1, `OFS_EVT_CLEAR, 32'h0000_0040);
		repeat (2) @(posedge pclk);
		check("irq off", 32'(irq), 32'h0000_0000);
		rd_chk(`OFS_EVT_STATUS, 32'h0000_0802, "after clear");
		apb(1'b1, `OFS_EVT_STATUS, 32'h0000_0FFF);
		apb(1'b1, `OFS_EVT_CLEAR, 32'h0000_0FFF);
		rd_chk(`OFS_EVT_STATUS, 32'h0000_0000, "status cleared");
		apb(1'b1, `OFS_POWER_CTRL, 32'h0000_0010);
		repeat (3) @(posedge pclk);
		check("port off", 32'(port_power_en), 32'h0000_0000);
		// Each fault in turn on port 0, interrupts enabled
		apb(1'b1, `OFS_EVT_ENABLE, 32'h0000_0111);
		for (int m = 1; m <= 3; m++)
		begin
			load_mode[0] <= 2'(m);
			apb(1'b1, `OFS_POWER_CTRL, 32'h0000_0001);
			wait_pwr(4'h1);
			if (m == 2)
			begin
				// Long enough that an unfrozen port would have tripped
				ce <= 1'b0;
				repeat (5000) @(posedge pclk);
				check("frozen power", 32'(port_power_en), 32'h0000_0001);
				ce <= 1'b1;
			end
			wait_pwr(4'h0);
			check("port0 irq", 32'(irq), 32'h0000_0001);
			rd_chk(`OFS_EVT_STATUS, 32'h0000_0001 << (4 * (m - 1)), "port0 fault");
			apb(1'b1, `OFS_EVT_CLEAR, 32'h0000_0111);
		end
		do_reset(1'b1);
		check("address high", 32'(mgmt_address), 32'h0000_0028);
		give_verdict();
	end
endmodule
`default_nettype wire
